// File: logic/sdgp_pkg.sv
// Purpose: shared constants for the sensor drive general-purpose port
// Assumes: 50 MHz clock, byte-addressed register bank on a 32-bit bus
// Notes:   offsets are byte addresses, one aligned word per register

`default_nettype none

package sdgp_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned PIN_COUNT = 2;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BE_W = 4;
    localparam int unsigned REG_W = 8;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] PORT_OUTPUT_CONTROL_OFS = 4'h0;
    localparam logic [3:0] PORT_INPUT_VALUE_OFS = 4'h4;
    localparam logic [3:0] CHIP_MODE_CONTROL_OFS = 4'h8;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned OUT_DATA_LSB = 0;
    localparam int unsigned OUT_DIR_LSB = 4;
    localparam int unsigned IN_VALUE_LSB = 0;
    localparam int unsigned REF_OUT_PIN_ZERO_BIT = 0;
    localparam int unsigned REF_IN_PIN_ONE_BIT = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0] OUT_DATA_RST = 2'h0;
    localparam logic [1:0] OUT_DIR_RST = 2'h3;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // bus handshake states
    // ------------------------------------------------------------
    typedef enum logic [0:0]
    {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } sdgp_bus_state_t;

endpackage : sdgp_pkg

`default_nettype wire

// File: logic/sdgp_sync2.sv
// Purpose: two-stage synchroniser for the port pin inputs
// Assumes: pins are asynchronous to clk
// Notes:   first stage is read only by the second stage

`timescale 1ns/1ps
`default_nettype none

module sdgp_sync2
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] async_in,
    output logic [1:0] sync_out
);

    logic [1:0] meta_r;
    logic [1:0] stable_r;

    // ------------------------------------------------------------
    // two flops, no logic between them
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= 2'h0;
            stable_r <= 2'h0;
        end
        else
        begin
            meta_r <= async_in;
            stable_r <= meta_r;
        end
    end

    assign sync_out = stable_r;

endmodule : sdgp_sync2

`default_nettype wire

// File: logic/sdgp_port.sv
// Purpose: two-pin general-purpose port with direction, drive and readback
// Assumes: Avalon-MM slave with waitrequest, 50 MHz clk, async active-low reset
// Notes:   pin controls are registered, so they follow a register write by one clock
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.

`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - each pin has its own direction bit in the output control register
// - direction bit one enables both receiver and driver of the pin
// - direction bit zero makes the pin input only, driver off
// - reset loads every direction bit with one
// - input register shows raw pin levels, no debounce or filter
// - receiver stays active while driving, readback shows true pin level
// - pin drives its output data bit only while direction bit is one
// - reset clears output data bits to zero
// - reference mode bits bypass digital function of pin zero or pin one
module sdgp_port
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [1:0] port_pin_in,
    output logic [1:0] port_pin_out,
    output logic [1:0] port_pin_oe,
    output logic ref_out_on_pin_zero,
    output logic ref_in_on_pin_one
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // drive enable per pin: direction set and not handed to analog use
    function automatic logic [1:0] pin_enable
    (
        input logic [1:0] dir,
        input logic [1:0] bypass
    );
        pin_enable = dir & ~bypass;
    endfunction : pin_enable

    // byte address match for a register, only lane 0 holds data
    function automatic logic hit
    (
        input logic [3:0] addr,
        input logic [3:0] ofs
    );
        hit = (addr == ofs);
    endfunction : hit

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    sdgp_pkg::sdgp_bus_state_t bus_state_r;
    sdgp_pkg::sdgp_bus_state_t bus_state_nxt;

    logic [1:0] out_data_r;
    logic [1:0] out_data_nxt;
    logic [1:0] out_dir_r;
    logic [1:0] out_dir_nxt;
    logic [1:0] mode_r;
    logic [1:0] mode_nxt;
    logic [1:0] in_value_r;
    logic [1:0] pin_sync;
    logic [1:0] bypass;
    logic [1:0] drive_en;
    logic [1:0] pin_out_nxt;
    logic [31:0] readdata_r;
    logic [31:0] readdata_nxt;
    logic [31:0] rd_word;
    logic waitrequest_r;
    logic [1:0] pin_out_r;
    logic [1:0] pin_oe_r;
    logic ref_out_r;
    logic ref_in_r;

    // decode is combinational; only the commit cycle may write a control register
    wire req = read | write;
    wire commit = (bus_state_r == sdgp_pkg::BUS_ACK);
    wire wr_commit = commit & write & byteenable[0];
    wire sel_out = hit(address, sdgp_pkg::PORT_OUTPUT_CONTROL_OFS);
    wire sel_in = hit(address, sdgp_pkg::PORT_INPUT_VALUE_OFS);
    wire sel_mode = hit(address, sdgp_pkg::CHIP_MODE_CONTROL_OFS);
    wire wr_out = wr_commit & sel_out;
    wire wr_mode = wr_commit & sel_mode;

    // ------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------
    // pins are asynchronous to clk, so nothing but the first flop sees them raw
    sdgp_sync2 u_sync
    (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(port_pin_in),
        .sync_out(pin_sync)
    );

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    // every access takes exactly one wait cycle, then one answer cycle
    always_comb
    begin
        bus_state_nxt = bus_state_r;
        case (bus_state_r)
            sdgp_pkg::BUS_IDLE:
            begin
                if (req)
                begin
                    bus_state_nxt = sdgp_pkg::BUS_ACK;
                end
            end
            sdgp_pkg::BUS_ACK:
            begin
                bus_state_nxt = sdgp_pkg::BUS_IDLE;
            end
            default:
            begin
                bus_state_nxt = sdgp_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_state_r <= sdgp_pkg::BUS_IDLE;
        end
        else
        begin
            bus_state_r <= bus_state_nxt;
        end
    end

    // built from the next state, so waitrequest drops in the answer cycle itself
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitrequest_r <= 1'b1;
        end
        else
        begin
            waitrequest_r <= ~(bus_state_nxt == sdgp_pkg::BUS_ACK);
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // unmapped offsets read as zero and still get an answer
    assign rd_word = sel_out ?
        {24'h00_0000, 2'h0, out_dir_r, 2'h0, out_data_r} :
        sel_in ? {30'h0000_0000, in_value_r} :
        sel_mode ? {30'h0000_0000, mode_r} :
        sdgp_pkg::READ_ZERO;

    // a read is captured when taken, one cycle ahead of its answer
    assign readdata_nxt = (bus_state_r == sdgp_pkg::BUS_IDLE && read) ?
        rd_word : readdata_r;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    assign out_data_nxt = wr_out ?
        writedata[sdgp_pkg::OUT_DATA_LSB +: 2] : out_data_r;
    assign out_dir_nxt = wr_out ?
        writedata[sdgp_pkg::OUT_DIR_LSB +: 2] : out_dir_r;
    assign mode_nxt = wr_mode ?
        {writedata[sdgp_pkg::REF_IN_PIN_ONE_BIT],
         writedata[sdgp_pkg::REF_OUT_PIN_ZERO_BIT]} : mode_r;

    // lane 0 carries every field, so a write without it changes nothing
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_data_r <= sdgp_pkg::OUT_DATA_RST;
        end
        else
        begin
            out_data_r <= out_data_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_dir_r <= sdgp_pkg::OUT_DIR_RST;
        end
        else
        begin
            out_dir_r <= out_dir_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_r <= sdgp_pkg::MODE_RST;
        end
        else
        begin
            mode_r <= mode_nxt;
        end
    end

    // read data is held until the next read is taken
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            readdata_r <= sdgp_pkg::READ_ZERO;
        end
        else
        begin
            readdata_r <= readdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // pin control
    // ------------------------------------------------------------
    // bypassed pins are left to the analog path: no drive, reads as zero
    assign bypass = {mode_r[sdgp_pkg::REF_IN_PIN_ONE_BIT],
                     mode_r[sdgp_pkg::REF_OUT_PIN_ZERO_BIT]};
    assign drive_en = pin_enable(out_dir_r, bypass);
    assign pin_out_nxt = out_data_r & drive_en;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_out_r <= 2'h0;
        end
        else
        begin
            pin_out_r <= pin_out_nxt;
        end
    end

    // driver off during reset; directions take effect one clock after release
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_oe_r <= 2'h0;
        end
        else
        begin
            pin_oe_r <= drive_en;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_out_r <= 1'b0;
            ref_in_r <= 1'b0;
        end
        else
        begin
            ref_out_r <= bypass[0];
            ref_in_r <= bypass[1];
        end
    end

    // no filter on purpose: noise on a pin shows up in the readback
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_value_r <= 2'h0;
        end
        else
        begin
            // receiver sampled regardless of drive, so readback is the true level
            in_value_r <= pin_sync & ~bypass;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign readdata = readdata_r;
    assign waitrequest = waitrequest_r;
    assign port_pin_out = pin_out_r;
    assign port_pin_oe = pin_oe_r;
    assign ref_out_on_pin_zero = ref_out_r;
    assign ref_in_on_pin_one = ref_in_r;

endmodule : sdgp_port

`default_nettype wire

// File: tb/sdgp_port_checker.sv
// Purpose: assertions on the port's bus answers and pin controls
// Assumes: one clock, async active-low reset
// Notes: readback is judged only once pins and bypass are quiet
`timescale 1ns/1ps
`default_nettype none
module sdgp_port_checker
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [1:0] port_pin_in,
    input wire logic [1:0] port_pin_out,
    input wire logic [1:0] port_pin_oe,
    input wire logic ref_out_on_pin_zero,
    input wire logic ref_in_on_pin_one
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic [1:0] byp = {ref_in_on_pin_one, ref_out_on_pin_zero};
    wire logic wr_ok = write && !waitrequest && byteenable[0];
    logic [3:0] calm_r;
    logic [3:0] seen_r;
    // synchroniser latency is not fixed here, so wait for quiet inputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            calm_r <= 4'h0;
            seen_r <= 4'h0;
        end
        else
        begin
            seen_r <= {byp, port_pin_in};
            calm_r <= (seen_r != {byp, port_pin_in}) ? 4'h0 : calm_r + {3'h0, calm_r != 4'hf};
        end
    end
    property p_ans; (read || write) && waitrequest |=> !waitrequest; endproperty
    a_ans: assert property (p_ans) else $error("bus not answered");
    property p_one; !waitrequest |=> waitrequest; endproperty
    a_one: assert property (p_one) else $error("answer too long");
    property p_rst; $rose(rst_n) |=> port_pin_oe == 2'h3 && port_pin_out == 2'h0 && byp == 2'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_oe;
        wr_ok && address == 4'h0 && !byp[0] |-> ##2 port_pin_oe[0] == $past(writedata[4], 2);
    endproperty
    a_oe: assert property (p_oe) else $error("direction not applied");
    property p_out; wr_ok && address == 4'h0 && !byp[0] |-> ##2
        port_pin_out[0] == ($past(writedata[0], 2) & $past(writedata[4], 2)); endproperty
    a_out: assert property (p_out) else $error("drive value wrong");
    property p_off; (port_pin_out & ~port_pin_oe) == 2'h0; endproperty
    a_off: assert property (p_off) else $error("drive while released");
    property p_ref; wr_ok && address == 4'h8 |-> ##2 byp == $past(writedata[1:0], 2); endproperty
    a_ref: assert property (p_ref) else $error("mode not applied");
    property p_byp; (byp & port_pin_oe) == 2'h0; endproperty
    a_byp: assert property (p_byp) else $error("bypassed pin driven");
    property p_rdin; read && !waitrequest && address == 4'h4 && calm_r > 4'h6 |->
        readdata == {30'h0, port_pin_in & ~byp}; endproperty
    a_rdin: assert property (p_rdin) else $error("input readback wrong");
endmodule : sdgp_port_checker
bind sdgp_port sdgp_port_checker u_chk (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .port_pin_in(port_pin_in),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
    .ref_out_on_pin_zero(ref_out_on_pin_zero), .ref_in_on_pin_one(ref_in_on_pin_one));
`default_nettype wire

// File: tb/sdgp_sensor.sv
// Purpose: sensor elements hanging on the two port pins
// Assumes: sensor always holds a level of its own
// Notes: the port wins where it drives
`timescale 1ns/1ps
`default_nettype none
module sdgp_sensor
(
    input wire logic [1:0] pin_drive,
    input wire logic [1:0] pin_oe,
    input wire logic [1:0] sensor_level,
    output logic [1:0] pin_level
);
    assign pin_level = (pin_oe & pin_drive) | (~pin_oe & sensor_level);
endmodule : sdgp_sensor
`default_nettype wire

// File: tb/tb.sv
// Purpose: random and corner tests of the port
// Assumes: one wait cycle per access is not relied upon
// Notes: expectations kept in ctl_m and mode_m
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [3:0] address = 4'h0;
    logic read = 1'h0;
    logic write = 1'h0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0] byteenable = 4'hf;
    logic [1:0] sensor_level = 2'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [1:0] pin_in;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    wire logic [1:0] byp;
    logic [7:0] ctl_m = 8'h30;
    logic [1:0] mode_m = 2'h0;
    int seed = 32'h0000_e746;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    sdgp_port DUT (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .port_pin_in(pin_in), .port_pin_out(pin_out),
        .port_pin_oe(pin_oe), .ref_out_on_pin_zero(byp[0]), .ref_in_on_pin_one(byp[1]));
    sdgp_sensor u_sensor (.pin_drive(pin_out), .pin_oe(pin_oe), .sensor_level(sensor_level),
        .pin_level(pin_in));
    always #10 clk = ~clk;
    task automatic test_done;
        if (n_fail == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_fail++;
            test_done;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'h0);
        q = readdata;
        read <= 1'h0;
        write <= 1'h0;
    endtask : bus
    function automatic logic [1:0] exp_oe(input logic [7:0] c, input logic [1:0] m);
        return c[5:4] & ~m;
    endfunction : exp_oe
    function automatic logic [1:0] exp_in(input logic [1:0] oe);
        return ((ctl_m[1:0] & oe) | (sensor_level & ~oe)) & ~mode_m;
    endfunction : exp_in
    task automatic check_all;
        logic [1:0] oe;
        logic [31:0] q;
        oe = exp_oe(ctl_m, mode_m);
        repeat (10) @(posedge clk);
        chk("oe", {30'h0, oe}, {30'h0, pin_oe});
        chk("out", {30'h0, ctl_m[1:0] & oe}, {30'h0, pin_out});
        chk("ref", {30'h0, mode_m}, {30'h0, byp});
        bus(1'h0, 4'h4, 32'h0000_0000, q);
        chk("input", {30'h0, exp_in(oe)}, q);
        bus(1'h0, 4'h0, 32'h0000_0000, q);
        chk("control", {24'h0, ctl_m}, q);
    endtask : check_all
    initial
    begin
        logic [31:0] q;
        logic [31:0] r;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        check_all;
        bus(1'h0, 4'hc, 32'h0000_0000, q);
        chk("unmapped", 32'h0000_0000, q);
        bus(1'h1, 4'h4, 32'hffff_ffff, q);
        byteenable <= 4'he;
        bus(1'h1, 4'h0, 32'hffff_ffff, q);
        byteenable <= 4'hf;
        check_all;
        for (int i = 0; i < 40; i++)
        begin
            r = $random(seed);
            sensor_level <= r[9:8];
            ctl_m = r[7:0] & 8'h33;
            bus(1'h1, 4'h0, r, q);
            if (i % 5 == 0)
            begin
                mode_m = 2'(i / 5);
                bus(1'h1, 4'h8, {r[31:2], mode_m}, q);
            end
            check_all;
        end
        rst_n <= 1'h0;
        ctl_m = 8'h30;
        mode_m = 2'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        check_all;
        test_done;
    end
endmodule : tb
`default_nettype wire
